/* sensor_serial_port.sv */
// Host serial port and start-up status logic of the measurement device
`timescale 1ns/100ps

// Summary of operation
// (R01) Held in reset while reset pin low
// (R02) Busy output low during start-up or conversion
// (R03) Output on falling edge, input on rising
// (R04) Data output high impedance while select high
// (R05) Frame runs from select fall to rise
// (R06) Status unreadable during analog power-up
// (R07) Digital init follows power-up immediately
// (R08) Status 0x80 during init, 0x40 after
// (R09) Store to nonvolatile within 2600 ms
// (R10) Reload from nonvolatile within 20 ms
// (R11) Default mux settling delay one ms
// (R12) Default rejection is 50 and 60 Hz
// (R13) Host serial clock at most 2 MHz; the bench host model runs it at 12.5 MHz
// (R14) Host waits for ready before commands; the bench host model sends them during power-up and while storing
module sensor_serial_port
  import sensor_port_pkg::*;
#(
  parameter int unsigned ANALOG_CYC = ANALOG_UP_CYC,
  parameter int unsigned INIT_CYC = DIGITAL_INIT_CYC,
  parameter int unsigned STORE_CYC = NV_STORE_CYC,
  parameter int unsigned LOAD_CYC = NV_LOAD_CYC,
  parameter int unsigned SETTLE_CYC = MUX_DELAY_CYC,
  parameter int unsigned CONVERT_CYC = CONV_CYC
) (
  input wire logic clk_in, // System clock, 25 MHz
  input wire logic rst_in, // Async reset, active high
  input wire logic reset_n_in, // Device reset pin, active low
  input wire logic sck_in, // Serial clock from host
  input wire logic cs_n_in, // Chip select, active low
  input wire logic sdi_in, // Serial data in
  output logic sdo_out, // Serial data out
  output logic sdo_oe_n_out, // Data out enable, low drives
  output logic busy_n_out, // Interrupt pin, low while busy
  output logic [1:0] rejection_out, // Mains rejection selection
  output logic [7:0] status_out // Command status register
);

  // ***********************************************
  // Reset pin synchroniser
  // ***********************************************
  logic [2:0] rstp_reg, rstp_next;
  logic pin_low_reg, pin_low_next;

  // Three stages; a change counts once stages two and three agree
  always_comb begin
    rstp_next = {rstp_reg[1:0], reset_n_in};
    pin_low_next = pin_low_reg;
    if (rstp_reg[1] == rstp_reg[2]) begin
      pin_low_next = ~rstp_reg[2];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rstp_reg <= 3'h0;
      pin_low_reg <= 1'b1;
    end else begin
      rstp_reg <= rstp_next;
      pin_low_reg <= pin_low_next;
    end
  end

  // ***********************************************
  // Start-up and operation sequencer
  // ***********************************************
  phase_t phase_reg, phase_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [7:0] stat_reg, stat_next;
  logic [1:0] rej_reg, rej_next;
  logic stat_ok_reg, stat_ok_next;
  logic cmd_tgl_sync; // Command toggle after crossing
  logic [2:0] tgl_sync_reg, tgl_sync_next; // Toggle synchroniser
  logic tgl_agree; // Stages two and three agree
  logic cmd_tgl_seen_reg, cmd_tgl_seen_next;
  logic [7:0] cmd_sys; // Command byte, stable when toggle seen
  logic cmd_new;

  // A toggle counts only once the last two stages agree
  assign tgl_agree = tgl_sync_reg[1] == tgl_sync_reg[2];
  assign cmd_new = tgl_agree && (cmd_tgl_sync != cmd_tgl_seen_reg);

  // Timer counts down phase lengths; each expiry moves the phase on
  always_comb begin
    phase_next = phase_reg;
    tmr_next = tmr_reg;
    stat_next = stat_reg;
    rej_next = rej_reg;
    stat_ok_next = stat_ok_reg;
    cmd_tgl_seen_next = cmd_tgl_seen_reg;
    if (tgl_agree) begin
      cmd_tgl_seen_next = cmd_tgl_sync;
    end
    if (tmr_reg != '0) begin
      tmr_next = tmr_reg - 1'b1;
    end
    if (pin_low_reg) begin
      phase_next = ST_ANALOG; // R01
      tmr_next = TMR_W'(ANALOG_CYC);
      stat_next = STAT_RESET;
      stat_ok_next = 1'b0; // R06
      rej_next = REJ_50_60; // R12
    end else begin
      unique case (phase_reg)
        ST_ANALOG: begin
          if (tmr_reg == '0) begin
            phase_next = ST_INIT; // R07
            tmr_next = TMR_W'(INIT_CYC);
            stat_next = STAT_INIT_START; // R08
            stat_ok_next = 1'b1;
          end
        end
        ST_INIT: begin
          if (tmr_reg == '0) begin
            phase_next = ST_IDLE;
            stat_next = STAT_INIT_DONE; // R08
          end
        end
        ST_IDLE: begin
          if (cmd_new) begin
            if (cmd_sys == CMD_CONVERT) begin
              phase_next = ST_SETTLE;
              tmr_next = TMR_W'(SETTLE_CYC); // R11
            end else if (cmd_sys == CMD_NV_STORE) begin
              phase_next = ST_NV_STORE;
              tmr_next = TMR_W'(STORE_CYC); // R09
            end else if (cmd_sys == CMD_NV_LOAD) begin
              phase_next = ST_NV_LOAD;
              tmr_next = TMR_W'(LOAD_CYC); // R10
            end
          end
        end
        ST_SETTLE: begin
          if (tmr_reg == '0) begin
            phase_next = ST_CONV;
            tmr_next = TMR_W'(CONVERT_CYC);
          end
        end
        ST_CONV, ST_NV_STORE, ST_NV_LOAD: begin
          if (tmr_reg == '0) begin
            phase_next = ST_IDLE;
          end
        end
        default: begin
          phase_next = ST_ANALOG;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= ST_ANALOG;
      tmr_reg <= '0;
      stat_reg <= STAT_RESET;
      rej_reg <= REJ_50_60;
      stat_ok_reg <= 1'b0;
      cmd_tgl_seen_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      tmr_reg <= tmr_next;
      stat_reg <= stat_next;
      rej_reg <= rej_next;
      stat_ok_reg <= stat_ok_next;
      cmd_tgl_seen_reg <= cmd_tgl_seen_next;
    end
  end

  // Busy pin: high only when settled idle
  logic busy_n_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_n_reg <= 1'b0;
    end else begin
      busy_n_reg <= (phase_next == ST_IDLE) && !pin_low_next; // R02
    end
  end
  assign busy_n_out = busy_n_reg;
  assign rejection_out = rej_reg;
  assign status_out = stat_reg;

  // ***********************************************
  // Status word crossing to the link domain
  // ***********************************************
  // Gated copy: reads 00 until power-up ends, then the status word
  logic [7:0] stat_hold_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_hold_reg <= 8'h00;
    end else begin
      stat_hold_reg <= stat_ok_reg ? stat_reg : 8'h00; // R06
    end
  end

  // ***********************************************
  // Link domain: serial shift logic on the host clock
  // ***********************************************
  // The host clock stops outside frames, so the frame state is
  // cleared asynchronously by chip select going high.
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shin_reg, shin_next;
  logic byte0_reg, byte0_next;
  logic cmd_tgl_reg, cmd_tgl_next;
  logic [7:0] cmd_reg, cmd_next;
  logic frame_rst;

  assign frame_rst = cs_n_in | rst_in; // R05

  // Shift in on rising edge; first full byte is the command
  always_comb begin
    shin_next = {shin_reg[6:0], sdi_in}; // R03
    bit_cnt_next = bit_cnt_reg + 3'h1;
    byte0_next = byte0_reg;
    cmd_tgl_next = cmd_tgl_reg;
    cmd_next = cmd_reg;
    if (bit_cnt_reg == 3'h7 && byte0_reg) begin
      byte0_next = 1'b0;
      cmd_next = {shin_reg[6:0], sdi_in};
      cmd_tgl_next = ~cmd_tgl_reg;
    end
  end

  always_ff @(posedge sck_in or posedge frame_rst) begin
    if (frame_rst) begin
      shin_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte0_reg <= 1'b1;
    end else begin
      shin_reg <= shin_next;
      bit_cnt_reg <= bit_cnt_next;
      byte0_reg <= byte0_next;
    end
  end

  // Command toggle survives the frame end so the sequencer sees it
  always_ff @(posedge sck_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_tgl_reg <= 1'b0;
      cmd_reg <= 8'h00;
    end else begin
      cmd_tgl_reg <= cmd_tgl_next;
      cmd_reg <= cmd_next;
    end
  end

  // Status snapshot at the select fall; the sequencer may move the word
  // later, but a frame otherwise shifts out one consistent byte. Limitation:
  // a status change within a clock of the select fall may mix bits.
  logic [7:0] snap_reg, snap_next;
  always_comb begin
    snap_next = stat_hold_reg; // R06
  end

  always_ff @(negedge cs_n_in or posedge rst_in) begin
    if (rst_in) begin
      snap_reg <= 8'h00;
    end else begin
      snap_reg <= snap_next;
    end
  end

  // Output bit index, advanced on each serial clock fall; bit 7 stands
  // from the select fall until the first fall
  logic [2:0] out_idx_reg, out_idx_next;
  always_comb begin
    out_idx_next = out_idx_reg + 3'h1;
  end

  always_ff @(negedge sck_in or posedge frame_rst) begin
    if (frame_rst) begin
      out_idx_reg <= 3'h0;
    end else begin
      out_idx_reg <= out_idx_next; // R03
    end
  end

  // Resets stay constant; the bit is picked by index instead of loaded
  assign sdo_out = snap_reg[3'h7 - out_idx_reg];
  assign sdo_oe_n_out = cs_n_in; // R04

  // ***********************************************
  // Command toggle crossing into the system clock
  // ***********************************************
  logic [7:0] cmd_cap_reg, cmd_cap_next;
  // The byte is copied every clock; it is only used once the toggle has
  // passed all three stages, by which time it has long stopped moving
  always_comb begin
    tgl_sync_next = {tgl_sync_reg[1:0], cmd_tgl_reg};
    cmd_cap_next = cmd_reg;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tgl_sync_reg <= 3'h0;
      cmd_cap_reg <= 8'h00;
    end else begin
      tgl_sync_reg <= tgl_sync_next;
      cmd_cap_reg <= cmd_cap_next;
    end
  end
  // Stage three used so the command byte has settled a cycle longer
  assign cmd_tgl_sync = tgl_sync_reg[2];
  assign cmd_sys = cmd_cap_reg; // R14
endmodule

/* sensor_port_pkg.sv */
// Constants and types shared by the host serial port design
package sensor_port_pkg;
  // Clock rate of the system clock in kHz
  localparam int unsigned CLK_KHZ = 25000;
  // Start-up phase lengths (analog power-up, digital init), in ms
  localparam int unsigned ANALOG_UP_MS = 1;
  localparam int unsigned DIGITAL_INIT_MS = 1;
  localparam int unsigned ANALOG_UP_CYC = ANALOG_UP_MS * CLK_KHZ;
  localparam int unsigned DIGITAL_INIT_CYC = DIGITAL_INIT_MS * CLK_KHZ;
  // Nonvolatile copy limits, longest time rounds down
  localparam int unsigned NV_STORE_MS = 2600;
  localparam int unsigned NV_LOAD_MS = 20;
  localparam int unsigned NV_STORE_CYC = NV_STORE_MS * CLK_KHZ;
  localparam int unsigned NV_LOAD_CYC = NV_LOAD_MS * CLK_KHZ;
  // Default multiplexer settling delay and conversion length
  localparam int unsigned MUX_DELAY_MS = 1;
  localparam int unsigned MUX_DELAY_CYC = MUX_DELAY_MS * CLK_KHZ;
  localparam int unsigned CONV_MS = 1;
  localparam int unsigned CONV_CYC = CONV_MS * CLK_KHZ;
  // Status register values
  localparam logic [7:0] STAT_INIT_START = 8'h80;
  localparam logic [7:0] STAT_INIT_DONE = 8'h40;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // Command codes carried in the first byte of a frame
  localparam logic [7:0] CMD_READ_STAT = 8'h01;
  localparam logic [7:0] CMD_CONVERT = 8'h02;
  localparam logic [7:0] CMD_NV_STORE = 8'h03;
  localparam logic [7:0] CMD_NV_LOAD = 8'h04;
  // Rejection selection encodings
  localparam logic [1:0] REJ_50_60 = 2'h0;
  localparam logic [1:0] REJ_60 = 2'h1;
  localparam logic [1:0] REJ_50 = 2'h2;
  // Width of the cycle timer
  localparam int unsigned TMR_W = 27;

  typedef enum logic [2:0] {
    ST_ANALOG = 3'b000,
    ST_INIT = 3'b001,
    ST_IDLE = 3'b011,
    ST_SETTLE = 3'b010,
    ST_CONV = 3'b110,
    ST_NV_STORE = 3'b111,
    ST_NV_LOAD = 3'b101
  } phase_t;
endpackage

/* sensor_serial_port_props.sv */
// Checker of start-up, busy and serial output timing
`timescale 1ns/100ps
module sensor_serial_port_props
  import sensor_port_pkg::*;
#(
  parameter int unsigned ANALOG_CYC = 20,
  parameter int unsigned INIT_CYC = 20,
  parameter int unsigned STORE_CYC = 40,
  parameter int unsigned LOAD_CYC = 30,
  parameter int unsigned SETTLE_CYC = 20,
  parameter int unsigned CONVERT_CYC = 20
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Async reset
  input wire logic reset_n_in, // Device reset pin
  input wire logic sck_in, // Serial clock
  input wire logic cs_n_in, // Chip select
  input wire logic sdi_in, // Serial data in
  input wire logic sdo_out, // Serial data out
  input wire logic sdo_oe_n_out, // Data out enable
  input wire logic busy_n_out, // Busy pin
  input wire logic [1:0] rejection_out, // Rejection select
  input wire logic [7:0] status_out // Status value
);
  localparam int ANA_LO = ANALOG_CYC;
  localparam int ANA_HI = ANALOG_CYC + 10;
  localparam int INI_LO = INIT_CYC;
  localparam int INI_HI = INIT_CYC + 2;
  localparam int UP_MAX = ANALOG_CYC + INIT_CYC + 12;
  localparam int RUN_MAX = STORE_CYC > LOAD_CYC ? STORE_CYC : LOAD_CYC;
  localparam int CMD_MAX = RUN_MAX > SETTLE_CYC + CONVERT_CYC ?
    RUN_MAX : SETTLE_CYC + CONVERT_CYC;
  localparam int LOW_MAX = UP_MAX > CMD_MAX + 6 ? UP_MAX : CMD_MAX + 6;
  int low_reg;
  int low_next;
  // Busy stretch length; the reset pin may hold busy forever, so restart
  always_comb low_next = (busy_n_out || !reset_n_in) ? 0 : low_reg + 1;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) low_reg <= 0;
    else low_reg <= low_next;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence init_begin;
    $rose(status_out == STAT_INIT_START);
  endsequence
  sequence init_end;
    $rose(status_out == STAT_INIT_DONE);
  endsequence
  a_reset_hold: assert property (
    !reset_n_in [*8] |-> !busy_n_out && status_out == STAT_RESET)
    else $error("device active while reset pin low");
  a_oe_follows_cs: assert property (
    sdo_oe_n_out == cs_n_in) else $error("data out enable not chip select");
  a_power_up: assert property (
    $rose(reset_n_in) |-> ##[ANA_LO:ANA_HI] init_begin)
    else $error("power-up length wrong");
  a_init_entry: assert property (
    init_begin |-> $past(status_out) == STAT_RESET)
    else $error("init not entered from power-up");
  a_init_length: assert property (
    init_begin |-> ##[INI_LO:INI_HI] init_end) else $error("init length");
  a_init_busy: assert property (
    status_out == STAT_INIT_START |-> !busy_n_out) else $error("busy in init");
  a_busy_release: assert property (
    init_end |-> ##[0:2] busy_n_out) else $error("busy not released");
  a_busy_bound: assert property (
    low_reg <= LOW_MAX) else $error("busy held too long");
  a_rej_default: assert property (
    rejection_out == REJ_50_60) else $error("rejection not default");
  a_sdo_steady: assert property (
    !cs_n_in && !$past(cs_n_in) && $changed(sdo_out) |-> $fell(sck_in))
    else $error("data out moved away from a serial clock fall");
endmodule
bind sensor_serial_port sensor_serial_port_props #(
  .ANALOG_CYC(ANALOG_CYC), .INIT_CYC(INIT_CYC), .STORE_CYC(STORE_CYC),
  .LOAD_CYC(LOAD_CYC), .SETTLE_CYC(SETTLE_CYC), .CONVERT_CYC(CONVERT_CYC)
) props (
  .clk_in(clk_in), .rst_in(rst_in), .reset_n_in(reset_n_in),
  .sck_in(sck_in), .cs_n_in(cs_n_in), .sdi_in(sdi_in), .sdo_out(sdo_out),
  .sdo_oe_n_out(sdo_oe_n_out), .busy_n_out(busy_n_out),
  .rejection_out(rejection_out), .status_out(status_out)
);

/* host_serial_model.sv */
// Serial master model standing in for the host controller
`timescale 1ns/100ps
module host_serial_model (
  output logic cs_n_out, // Chip select
  output logic sck_out, // Serial clock, still between frames
  output logic sdi_out, // Serial data to device
  input wire logic sdo_in, // Serial data from device
  input wire logic sdo_oe_n_in // Low while device drives
);
  logic line;
  // Released line shows the inverse so a stale value never passes
  always_comb line = sdo_oe_n_in ? ~sdo_in : sdo_in;
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end
  // One framed byte, MSB first, 80 ns serial clock period
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] rx);
    #13 cs_n_out = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      sdi_out = cmd[i];
      #40 sck_out = 1'b1;
      rx[i] = line;
      #40 sck_out = 1'b0;
    end
    #100 cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #400;
  endtask
endmodule

/* sensor_hub_host_serial_port_bench.sv */
// Self-checking bench for the host serial port
`timescale 1ns/100ps
module sensor_hub_host_serial_port_bench;
  import sensor_port_pkg::*;
  localparam int A = 20, I = 20, S = 40, L = 30, M = 20, C = 20;
  logic clk_in = 1'b0, rst_in = 1'b1, reset_n_in = 1'b0;
  logic sck_in, cs_n_in, sdi_in, sdo_out, sdo_oe_n_out, busy_n_out;
  logic [1:0] rejection_out;
  logic [7:0] status_out, rx;
  int fails = 0, compares = 0, n, len;
  always #20 clk_in = ~clk_in;
  sensor_serial_port #(.ANALOG_CYC(A), .INIT_CYC(I), .STORE_CYC(S),
    .LOAD_CYC(L), .SETTLE_CYC(M), .CONVERT_CYC(C)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .reset_n_in(reset_n_in),
    .sck_in(sck_in), .cs_n_in(cs_n_in), .sdi_in(sdi_in), .sdo_out(sdo_out),
    .sdo_oe_n_out(sdo_oe_n_out), .busy_n_out(busy_n_out),
    .rejection_out(rejection_out), .status_out(status_out));
  host_serial_model host (.cs_n_out(cs_n_in), .sck_out(sck_in),
    .sdi_out(sdi_in), .sdo_in(sdo_out), .sdo_oe_n_in(sdo_oe_n_out));
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_count(string what, int lo, int hi, int got);
    compares++;
    if (got < lo || got > hi) begin
      fails++;
      $display("mismatch %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cycles of the next busy stretch; 0 when none starts in 60 cycles
  task automatic measure(output int cnt);
    int w;
    w = 0;
    cnt = 0;
    while (busy_n_out !== 1'b0 && w < 60) begin
      step;
      w++;
    end
    while (busy_n_out === 1'b0 && cnt < 200) begin
      step;
      cnt++;
    end
  endtask
  // Start-up phases timed while the host reads status in power-up
  task automatic t_startup;
    reset_n_in = 1'b1;
    fork
      host.xfer(CMD_READ_STAT, rx);
      begin
        for (n = 0; status_out !== STAT_INIT_START && n < 60; n++) step;
        check_count("power-up cycles", A, A + 10, n);
        for (n = 0; status_out !== STAT_INIT_DONE && n < 60; n++) step;
        check_count("init cycles", I, I + 2, n);
        repeat (2) step;
        check_byte("busy after init", 8'h01, {7'h00, busy_n_out});
      end
    join
    check_byte("status in power-up", STAT_RESET, rx);
    host.xfer(CMD_READ_STAT, rx);
    check_byte("status ready", STAT_INIT_DONE, rx);
    check_byte("oe idle", 8'h01, {7'h00, sdo_oe_n_out});
    check_byte("rejection", {6'h00, REJ_50_60}, {6'h00, rejection_out});
  endtask
  // Every code: timed ones busy for their length, others ignored
  task automatic t_commands;
    logic [7:0] cmd [5] = '{CMD_CONVERT, CMD_NV_STORE, CMD_NV_LOAD,
      CMD_READ_STAT, 8'hFF};
    int lo [5] = '{M + C, S, L, 0, 0};
    for (int k = 0; k < 5; k++) begin
      fork
        host.xfer(cmd[k], rx);
        measure(len);
      join
      check_count("busy cycles", lo[k], lo[k] + 3, len);
    end
  endtask
  // A command sent while storing is dropped
  task automatic t_refuse;
    fork
      begin
        host.xfer(CMD_NV_STORE, rx);
        host.xfer(CMD_CONVERT, rx);
      end
      begin
        measure(len);
        check_count("store busy", S, S + 3, len);
        measure(len);
        check_count("refused busy", 0, 0, len);
      end
    join
  endtask
  // Reset pin pulled in during the settling delay after a convert command, then a fresh start-up
  task automatic t_reset_mid;
    host.xfer(CMD_CONVERT, rx);
    reset_n_in = 1'b0;
    repeat (8) step;
    check_byte("status held", STAT_RESET, status_out);
    check_byte("busy held", 8'h00, {7'h00, busy_n_out});
    reset_n_in = 1'b1;
    for (n = 0; busy_n_out !== 1'b1 && n < 100; n++) step;
    check_byte("status restart", STAT_INIT_DONE, status_out);
  endtask
  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rst_in = 1'b0;
    step;
    t_startup;
    t_commands;
    t_refuse;
    t_reset_mid;
    tally_and_finish;
  end
endmodule
